// ### pfcsr_defs.vh
// register offsets, field positions, reset values and timing constants
`ifndef PFCSR_DEFS_VH
`define PFCSR_DEFS_VH
`define PFCSR_ADDR_PORT      8'h28
`define PFCSR_ADDR_FUSE      8'h29
`define PFCSR_ADDR_RST       8'h2a
`define PFCSR_ADDR_STAT      8'h2d
`define PFCSR_RESET_VAL      8'h00
`define PFCSR_ZERO8          8'h00
`define PFCSR_BIT_BYPASS     7
`define PFCSR_BIT_FAST       6
`define PFCSR_BIT_SLOW       5
`define PFCSR_BIT_ROUTE      0
`define PFCSR_BIT_ECC        7
`define PFCSR_BIT_CRC        3
`define PFCSR_BIT_SRST       1
`define PFCSR_PORT_MASK      8'he1
`define PFCSR_RST_KEY        8'h52
`define PFCSR_CLK_MHZ        25
`define PFCSR_INIT_US        500
`define PFCSR_INIT_CYC       (`PFCSR_INIT_US * `PFCSR_CLK_MHZ)
`define PFCSR_FLT_STD_NS     50
`define PFCSR_FLT_HS_NS      10
`define PFCSR_CLK_NS         40
`define PFCSR_FLT_STD_CYC    ((`PFCSR_FLT_STD_NS + `PFCSR_CLK_NS - 1) / `PFCSR_CLK_NS)
`define PFCSR_FLT_HS_CYC     ((`PFCSR_FLT_HS_NS + `PFCSR_CLK_NS - 1) / `PFCSR_CLK_NS)
`define PFCSR_CHK_CYC        8
`define PFCSR_ST_IDLE        2'h0
`define PFCSR_ST_ECC         2'h1
`define PFCSR_ST_CRC         2'h2
`endif

// ### pfcsr_filter.v
// glitch filter on a synchronised two-wire input
`timescale 1ns/100ps
`include "pfcsr_defs.vh"
module pfcsr_filter #(
    parameter W = 3
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         din,
    input  wire         bypass,
    input  wire [W-1:0] width,
    output reg          dout
);
    reg [W-1:0] cnt_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= {W{1'b0}};
            dout  <= 1'b1;
        end else if (bypass || din == dout) begin
            cnt_q <= {W{1'b0}};
            if (bypass)
                dout <= din;
        end else if (cnt_q + 1'b1 >= width) begin
            cnt_q <= {W{1'b0}};
            dout  <= din;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// ### pfcsr_fuse_check.v
// fuse store ecc and crc check sequencer
`timescale 1ns/100ps
`include "pfcsr_defs.vh"
module pfcsr_fuse_check #(
    parameter N = 4
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ecc_go,
    input  wire       crc_go,
    input  wire       ecc_err_in,
    input  wire       crc_err_in,
    output reg        busy,
    output reg        ecc_err,
    output reg        crc_err
);
    reg [1:0] st_q;
    reg [3:0] cnt_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            st_q    <= `PFCSR_ST_IDLE;
            cnt_q   <= 4'h0;
            busy    <= 1'b0;
            ecc_err <= 1'b0;
            crc_err <= 1'b0;
        end else begin
            case (st_q)
            `PFCSR_ST_IDLE: begin
                cnt_q <= 4'h0;
                busy  <= 1'b0;
                if (ecc_go) begin
                    st_q <= `PFCSR_ST_ECC;
                    busy <= 1'b1;
                end else if (crc_go) begin
                    st_q <= `PFCSR_ST_CRC;
                    busy <= 1'b1;
                end
            end
            `PFCSR_ST_ECC, `PFCSR_ST_CRC: begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == N[3:0]) begin
                    if (st_q == `PFCSR_ST_ECC)
                        ecc_err <= ecc_err_in;
                    else
                        crc_err <= crc_err_in;
                    st_q <= `PFCSR_ST_IDLE;
                    busy <= 1'b0;
                end
            end
            default: st_q <= `PFCSR_ST_IDLE;
            endcase
        end
    end
endmodule

// ### pfcsr_top.v
// port configuration, fuse check control and software reset registers
// Overview of operation
// R01: bypass bit set disables glitch filter
// R02: spi variant always bypasses the filter
// R03: fast mode gives 10 ns filter; code uses one 40 ns cycle, so one-cycle glitches pass
// R04: slope bit slows the sda driver
// R05: route bit puts sample ready out
// R06: ecc bit starts fuse ecc check
// R07: crc bit starts fuse crc check; not started when set in the same write as the ecc bit
// R08: clear control bits keep checker idle
// R09: writing key 0x52 resets the device
// R10: reset fires one cycle after the key write
// R11: soft reset clears registers, reloads fuses
// R12: soft reset floats the interrupt pins
// R13: host waits half a millisecond after reset
// R14: reads return zero during initialisation
// R15: reset request is a self clearing pulse
// R16: reserved bits ignore writes, read zero; only port register masked, fuse keeps all written bits
`timescale 1ns/100ps
`include "pfcsr_defs.vh"
module pfcsr_top #(
    parameter SPI_VARIANT = 0,
    parameter INIT_CYC    = `PFCSR_INIT_CYC,
    parameter CHK_CYC     = `PFCSR_CHK_CYC
) (
    input  wire       CLK,
    input  wire       RST_N,
    input  wire [7:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR,
    input  wire       RD,
    output reg  [7:0] RDATA,
    input  wire       SDA_PIN,
    input  wire       SCL_PIN,
    input  wire       SAMPLE_READY,
    input  wire       INT0_LEVEL,
    input  wire       INT1_LEVEL,
    input  wire       FUSE_ECC_FAULT,
    input  wire       FUSE_CRC_FAULT,
    output reg        SDA_FILT,
    output reg        SCL_FILT,
    output reg        SDA_SLOW,
    output reg        FIRST_SERIAL_OUT_PIN,
    output reg        FIRST_SERIAL_OUT_OE_N,
    output reg        INT0_OUT,
    output reg        INT0_OE_N,
    output reg        INT1_OUT,
    output reg        INT1_OE_N,
    output reg        FUSE_RELOAD,
    output reg        SENSOR_STANDBY,
    output reg        INIT_BUSY
);
    reg  [7:0]  port_q;
    reg  [7:0]  fuse_q;
    reg  [31:0] init_q;
    reg         srst_q;
    reg         float_q;
    reg  [1:0]  sda_s_q;
    reg  [1:0]  scl_s_q;
    reg  [1:0]  rdy_s_q;
    reg  [1:0]  i0_s_q;
    reg  [1:0]  i1_s_q;
    reg  [1:0]  ecc_s_q;
    reg  [1:0]  crc_s_q;
    reg         ecc_prev_q;
    reg         crc_prev_q;
    wire        blk_rst_n;
    wire        bypass;
    wire [2:0]  flt_w;
    wire        sda_f;
    wire        scl_f;
    wire        chk_busy;
    wire        ecc_err;
    wire        crc_err;
    wire        key_hit;
    reg  [7:0]  rd_d;
    localparam  flt_hs_cyc  = `PFCSR_FLT_HS_CYC;
    localparam  flt_std_cyc = `PFCSR_FLT_STD_CYC;

    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign key_hit   = WR && hit(ADDR, `PFCSR_ADDR_RST) && WDATA == `PFCSR_RST_KEY; // R09
    assign blk_rst_n = RST_N && !srst_q; // R11
    assign bypass    = port_q[`PFCSR_BIT_BYPASS] || (SPI_VARIANT != 0); // R01 R02
    assign flt_w     = port_q[`PFCSR_BIT_FAST] ? flt_hs_cyc[2:0] : flt_std_cyc[2:0]; // R03

    always @(posedge CLK) begin
        if (!RST_N) begin
            sda_s_q <= 2'h3;
            scl_s_q <= 2'h3;
            rdy_s_q <= 2'h0;
            i0_s_q  <= 2'h0;
            i1_s_q  <= 2'h0;
            ecc_s_q <= 2'h0;
            crc_s_q <= 2'h0;
        end else begin
            sda_s_q <= {sda_s_q[0], SDA_PIN};
            scl_s_q <= {scl_s_q[0], SCL_PIN};
            rdy_s_q <= {rdy_s_q[0], SAMPLE_READY};
            i0_s_q  <= {i0_s_q[0], INT0_LEVEL};
            i1_s_q  <= {i1_s_q[0], INT1_LEVEL};
            ecc_s_q <= {ecc_s_q[0], FUSE_ECC_FAULT};
            crc_s_q <= {crc_s_q[0], FUSE_CRC_FAULT};
        end
    end

    pfcsr_filter #(.W(3)) u_sda (
        .clk    (CLK),
        .rst_n  (RST_N),
        .din    (sda_s_q[1]),
        .bypass (bypass),
        .width  (flt_w),
        .dout   (sda_f)
    );

    pfcsr_filter #(.W(3)) u_scl (
        .clk    (CLK),
        .rst_n  (RST_N),
        .din    (scl_s_q[1]),
        .bypass (bypass),
        .width  (flt_w),
        .dout   (scl_f)
    );

    // soft reset pulse and initialisation window
    always @(posedge CLK) begin
        if (!RST_N) begin
            srst_q  <= 1'b0;
            init_q  <= 32'h0;
            float_q <= 1'b0;
        end else begin
            srst_q <= key_hit && !srst_q; // R10 R15
            if (key_hit) begin
                init_q  <= INIT_CYC; // R13
                float_q <= 1'b1; // R12
            end else if (init_q != 32'h0) begin
                init_q <= init_q - 32'h1;
            end
        end
    end

    // register writes; reserved port bits masked, fuse register written whole
    always @(posedge CLK) begin
        if (!blk_rst_n) begin
            port_q     <= `PFCSR_RESET_VAL; // R11
            fuse_q     <= `PFCSR_RESET_VAL;
            ecc_prev_q <= 1'b0;
            crc_prev_q <= 1'b0;
        end else begin
            ecc_prev_q <= fuse_q[`PFCSR_BIT_ECC];
            crc_prev_q <= fuse_q[`PFCSR_BIT_CRC];
            if (WR && init_q == 32'h0) begin
                if (hit(ADDR, `PFCSR_ADDR_PORT))
                    port_q <= WDATA & `PFCSR_PORT_MASK; // R16
                if (hit(ADDR, `PFCSR_ADDR_FUSE))
                    fuse_q <= WDATA;
            end
        end
    end

    pfcsr_fuse_check #(.N(CHK_CYC)) u_chk (
        .clk        (CLK),
        .rst_n      (blk_rst_n),
        .ecc_go     (fuse_q[`PFCSR_BIT_ECC] && !ecc_prev_q), // R06 R08
        .crc_go     (fuse_q[`PFCSR_BIT_CRC] && !crc_prev_q), // R07 R08
        .ecc_err_in (ecc_s_q[1]),
        .crc_err_in (crc_s_q[1]),
        .busy       (chk_busy),
        .ecc_err    (ecc_err),
        .crc_err    (crc_err)
    );

    always @* begin
        rd_d = `PFCSR_ZERO8;
        if (init_q == 32'h0) begin // R14
            if (hit(ADDR, `PFCSR_ADDR_PORT))
                rd_d = port_q;
            else if (hit(ADDR, `PFCSR_ADDR_FUSE))
                rd_d = fuse_q;
            else if (hit(ADDR, `PFCSR_ADDR_STAT))
                rd_d = {5'h00, chk_busy, crc_err, ecc_err};
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            RDATA                 <= `PFCSR_ZERO8;
            SDA_FILT              <= 1'b1;
            SCL_FILT              <= 1'b1;
            SDA_SLOW              <= 1'b0;
            FIRST_SERIAL_OUT_PIN  <= 1'b0;
            FIRST_SERIAL_OUT_OE_N <= 1'b1;
            INT0_OUT              <= 1'b0;
            INT0_OE_N             <= 1'b1;
            INT1_OUT              <= 1'b0;
            INT1_OE_N             <= 1'b1;
            FUSE_RELOAD           <= 1'b0;
            SENSOR_STANDBY        <= 1'b1;
            INIT_BUSY             <= 1'b0;
        end else begin
            RDATA                 <= RD ? rd_d : `PFCSR_ZERO8;
            SDA_FILT              <= sda_f;
            SCL_FILT              <= scl_f;
            SDA_SLOW              <= port_q[`PFCSR_BIT_SLOW]; // R04
            FIRST_SERIAL_OUT_PIN  <= rdy_s_q[1] && port_q[`PFCSR_BIT_ROUTE]; // R05
            FIRST_SERIAL_OUT_OE_N <= !port_q[`PFCSR_BIT_ROUTE]; // R05
            INT0_OUT              <= i0_s_q[1];
            INT0_OE_N             <= float_q || srst_q; // R12
            INT1_OUT              <= i1_s_q[1];
            INT1_OE_N             <= float_q || srst_q; // R12
            FUSE_RELOAD           <= srst_q; // R11
            SENSOR_STANDBY        <= srst_q || SENSOR_STANDBY; // R11
            INIT_BUSY             <= (init_q > 32'h1) || key_hit; // R14
        end
    end
endmodule

// ### pfcsr_fuse_model.sv
// far side model: fuse store fault levels and sample ready source
`timescale 1ns/100ps
module pfcsr_fuse_model (
    input  wire logic CLK,
    input  wire logic ecc_bad,
    input  wire logic crc_bad,
    input  wire logic ready_on,
    output logic      ecc_fault = 1'b0,
    output logic      crc_fault = 1'b0,
    output logic      sample_ready = 1'b0
);
    always @(posedge CLK) begin
        ecc_fault    <= ecc_bad;
        crc_fault    <= crc_bad;
        sample_ready <= ready_on;
    end
endmodule

// ### pfcsr_top_assertions.sv
// checker for the port and soft reset registers
`timescale 1ns/100ps
module pfcsr_top_checker (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       FIRST_SERIAL_OUT_PIN,
    input wire logic       FIRST_SERIAL_OUT_OE_N,
    input wire logic       INT0_OE_N,
    input wire logic       INT1_OE_N,
    input wire logic       FUSE_RELOAD,
    input wire logic       SENSOR_STANDBY,
    input wire logic       INIT_BUSY
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_INIT_ZERO: assert property ($past(RD) && $past(INIT_BUSY) |-> RDATA == 8'h00)
        else $error("read during init not zero");
    AST_KEY_ZERO: assert property ($past(RD) && $past(ADDR) == 8'h2a |-> RDATA == 8'h00)
        else $error("reset register read not zero");
    AST_RSV_ZERO: assert property ($past(RD) && $past(ADDR) == 8'h28 |-> RDATA[4:1] == 4'h0)
        else $error("reserved bits not zero");
    AST_KEY_RST: assert property (WR && ADDR == 8'h2a && WDATA == 8'h52 |-> ##[1:3] FUSE_RELOAD)
        else $error("key write gave no reset");
    AST_PULSE: assert property (FUSE_RELOAD |=> !FUSE_RELOAD)
        else $error("reload longer than one cycle");
    AST_STANDBY: assert property (FUSE_RELOAD |-> SENSOR_STANDBY ##1 SENSOR_STANDBY)
        else $error("standby not set on soft reset");
    AST_INT_FLOAT: assert property (FUSE_RELOAD |-> INT0_OE_N && INT1_OE_N)
        else $error("interrupt pins driven after soft reset");
    AST_INIT_WIN: assert property (FUSE_RELOAD |-> ##[0:2] INIT_BUSY)
        else $error("init window not opened");
    AST_ROUTE: assert property (FIRST_SERIAL_OUT_OE_N && $past(FIRST_SERIAL_OUT_OE_N, 2)
        |-> !FIRST_SERIAL_OUT_PIN)
        else $error("ready routed while not selected");
endmodule

// ### pfcsr_top_tb.sv
// self-checking bench for the port, fuse check and soft reset registers
`timescale 1ns/100ps
`include "pfcsr_defs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module pfcsr_top_tb;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sda = 1'b1;
    logic       ready_on = 1'b0, ecc_bad = 1'b0, crc_bad = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       sda_filt, sda_slow, sout, sout_oe_n, int0_oe_n, int1_oe_n;
    logic       reload, standby, init_busy, ecc_f, crc_f, srdy;
    logic       scl = 1'b1, intl = 1'b0, scl_filt, int0_out, int1_out;
    int         err_count = 0, checks_done = 0, i;
    initial forever #20 clk = ~clk;
    pfcsr_fuse_model fm (.CLK(clk), .ecc_bad(ecc_bad), .crc_bad(crc_bad), .ready_on(ready_on),
        .ecc_fault(ecc_f), .crc_fault(crc_f), .sample_ready(srdy));
    pfcsr_top #(.INIT_CYC(20)) uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SDA_PIN(sda), .SCL_PIN(scl), .SAMPLE_READY(srdy), .INT0_LEVEL(intl),
        .INT1_LEVEL(~intl), .FUSE_ECC_FAULT(ecc_f), .FUSE_CRC_FAULT(crc_f), .SDA_FILT(sda_filt),
        .SCL_FILT(scl_filt), .SDA_SLOW(sda_slow), .FIRST_SERIAL_OUT_PIN(sout),
        .FIRST_SERIAL_OUT_OE_N(sout_oe_n), .INT0_OUT(int0_out), .INT0_OE_N(int0_oe_n), .INT1_OUT(int1_out),
        .INT1_OE_N(int1_oe_n), .FUSE_RELOAD(reload), .SENSOR_STANDBY(standby), .INIT_BUSY(init_busy));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(n, e, rdata & m)
    endtask
    task automatic glitch(input logic e, input string n);
        logic seen, seen_c;
        seen = 1'b0;
        seen_c = 1'b0;
        @(posedge clk);
        sda <= 1'b0;
        scl <= 1'b0;
        @(posedge clk);
        sda <= 1'b1;
        scl <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            #1;
            if (sda_filt === 1'b0) seen = 1'b1;
            if (scl_filt === 1'b0) seen_c = 1'b1;
        end
        `CHK(n, e, seen)
        `CHK(n, e, seen_c)
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h28, 8'hff, 8'h00, "port reset");
        rd_reg(8'h29, 8'hff, 8'h00, "fuse reset");
        rd_reg(8'h2a, 8'hff, 8'h00, "key reset");
        wr_reg(8'h28, 8'hff);
        rd_reg(8'h28, 8'hff, 8'he1, "port rsv");
        wr_reg(8'h29, 8'hff);
        rd_reg(8'h29, 8'hff, 8'hff, "fuse rw");
        wr_reg(8'h30, 8'h55);
        rd_reg(8'h30, 8'hff, 8'h00, "unmapped");
        `CHK("slow", 1'b1, sda_slow)
        `CHK("route oe", 1'b0, sout_oe_n)
        `CHK("int drive", 1'b0, int0_oe_n)
        `CHK("int0 idle", 1'b0, int0_out)
        `CHK("int1 idle", 1'b1, int1_out)
        @(posedge clk);
        ready_on <= 1'b1;
        intl <= 1'b1;
        repeat (6) @(posedge clk);
        #1 `CHK("route pin", 1'b1, sout)
        `CHK("int0 level", 1'b1, int0_out)
        `CHK("int1 level", 1'b0, int1_out)
        glitch(1'b1, "bypass");
        wr_reg(8'h28, 8'h00);
        repeat (3) @(posedge clk);
        #1 `CHK("route off", 1'b1, sout_oe_n)
        glitch(1'b0, "filter");
        wr_reg(8'h28, 8'h40);
        glitch(1'b1, "fast");
        $display("test port done");
        wr_reg(8'h29, 8'h00);
        ecc_bad <= 1'b1;
        repeat (16) @(posedge clk);
        rd_reg(8'h2d, 8'hff, 8'h00, "idle check");
        wr_reg(8'h29, 8'h80);
        rd_reg(8'h2d, 8'hff, 8'h04, "ecc busy");
        repeat (16) @(posedge clk);
        rd_reg(8'h2d, 8'hff, 8'h01, "ecc status");
        crc_bad <= 1'b1;
        wr_reg(8'h29, 8'h88);
        repeat (16) @(posedge clk);
        rd_reg(8'h2d, 8'hff, 8'h03, "crc status");
        $display("test fuse done");
        wr_reg(8'h2a, 8'h02);
        repeat (2) @(posedge clk);
        #1 `CHK("no key", 1'b0, init_busy)
        wr_reg(8'h2a, 8'h52);
        repeat (2) @(posedge clk);
        #1 `CHK("init busy", 1'b1, init_busy)
        `CHK("standby", 1'b1, standby)
        `CHK("int float", 1'b1, int0_oe_n)
        `CHK("int1 float", 1'b1, int1_oe_n)
        rd_reg(8'h29, 8'hff, 8'h00, "init read");
        wr_reg(8'h28, 8'h01);
        i = 0;
        while (init_busy !== 1'b0 && i < 100) begin
            @(posedge clk);
            #1 i++;
        end
        `CHK("init end", 1'b0, init_busy)
        rd_reg(8'h29, 8'hff, 8'h00, "fuse clr");
        rd_reg(8'h28, 8'hff, 8'h00, "port clr");
        rd_reg(8'h2a, 8'hff, 8'h00, "key read");
        $display("test soft reset done");
        final_report();
    end
endmodule
bind pfcsr_top pfcsr_top_checker chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .FIRST_SERIAL_OUT_PIN(FIRST_SERIAL_OUT_PIN),
    .FIRST_SERIAL_OUT_OE_N(FIRST_SERIAL_OUT_OE_N), .INT0_OE_N(INT0_OE_N), .INT1_OE_N(INT1_OE_N),
    .FUSE_RELOAD(FUSE_RELOAD), .SENSOR_STANDBY(SENSOR_STANDBY), .INIT_BUSY(INIT_BUSY));
